/* rtl/cssfd_pkg.sv */
// Constants and types shared by the serial slave channel
package cssfd_pkg;

   //**********************************************
   // Bus
   //**********************************************
   localparam int         APB_AW      = 8;
   localparam int         APB_DW      = 32;
   localparam int         DATA_W      = 8;

   //**********************************************
   // Register offsets
   //**********************************************
   localparam logic [7:0] ADDR_DATA   = 8'h00;
   localparam logic [7:0] ADDR_MODE   = 8'h04;
   localparam logic [7:0] ADDR_CFG    = 8'h08;
   localparam logic [7:0] ADDR_STAT   = 8'h0C;
   localparam logic [7:0] ADDR_FCLR   = 8'h10;
   localparam logic [7:0] ADDR_CTRL   = 8'h14;
   localparam logic [7:0] ADDR_COUNT  = 8'h18;
   localparam logic [7:0] ADDR_ISTAT  = 8'h1C;
   localparam logic [7:0] ADDR_IMASK  = 8'h20;

   //**********************************************
   // Field positions
   //**********************************************
   localparam int         MODE_ISEL   = 0;
   localparam int         CFG_DAP     = 0;
   localparam int         CFG_CKP     = 1;
   localparam int         CFG_LSB     = 2;
   localparam int         CFG_LEN8    = 3;
   localparam int         STAT_OVF    = 0;
   localparam int         STAT_BFF    = 1;
   localparam int         STAT_BUSY   = 2;
   localparam int         STAT_RUN    = 3;
   localparam int         FCLR_OVF    = 0;
   localparam int         CTRL_START  = 0;
   localparam int         CTRL_STOP   = 1;
   localparam int         CTRL_PCE    = 2;
   localparam int         CTRL_RUN    = 3;
   localparam int         IRQ_CH      = 0;
   localparam int         IRQ_OVF     = 1;

   //**********************************************
   // Reset values and frame lengths
   //**********************************************
   localparam logic [3:0] CFG_RST     = 4'h8;
   localparam logic       MODE_RST    = 1'b0;
   localparam logic       PCE_RST     = 1'b0;
   localparam logic [1:0] IMASK_RST   = 2'h0;
   localparam logic [3:0] LEN8_BITS   = 4'h8;
   localparam logic [3:0] LEN7_BITS   = 4'h7;

   //**********************************************
   // Timing
   //**********************************************
   localparam int         CLK_NS      = 5;
   localparam int         QUIET_NS    = 1000;
   localparam logic [7:0] QUIET_CYC   = 8'(QUIET_NS / CLK_NS);
   localparam int         MCK_PER_SCK = 6;

   typedef enum logic [1:0] {
      ST_STOP  = 2'b00,
      ST_RUN   = 2'b01,
      ST_OFF   = 2'b11,
      ST_DRAIN = 2'b10
   } cssfd_state_t;

endpackage : cssfd_pkg

/* rtl/cssfd_shift_if.sv */
// Signals between channel control and shift engine
interface cssfd_shift_if;
   logic       clr;
   logic       load;
   logic [7:0] load_data;
   logic       out_edge;
   logic       smp_edge;
   logic       si;
   logic       dap;
   logic       len8;
   logic       lsb;
   logic       so;
   logic       done;
   logic [7:0] rx_data;
   logic       busy;

   modport ctl (
      output clr, load, load_data, out_edge, smp_edge, si, dap, len8, lsb,
      input  so, done, rx_data, busy
   );
   modport eng (
      input  clr, load, load_data, out_edge, smp_edge, si, dap, len8, lsb,
      output so, done, rx_data, busy
   );
endinterface : cssfd_shift_if

/* rtl/cssfd_sync.sv */
// Three stage pin synchroniser with agreement filter and edge pulses
module cssfd_sync #(
   parameter logic RST_LVL = 1'b1
) (
   input  wire logic i_clk,
   input  wire logic i_arst_n,
   input  wire logic i_pin,
   output logic      o_lvl,
   output logic      o_rise,
   output logic      o_fall
);
   logic [2:0] ff_r;
   logic       lvl_r;
   logic       lvl_nxt;
   logic       rise_r;
   logic       fall_r;

   assign lvl_nxt = (ff_r[1] == ff_r[2]) ? ff_r[2] : lvl_r;
   assign o_lvl   = lvl_r;
   assign o_rise  = rise_r;
   assign o_fall  = fall_r;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ff_r   <= {3{RST_LVL}};
         lvl_r  <= RST_LVL;
         rise_r <= 1'b0;
         fall_r <= 1'b0;
      end else begin
         ff_r   <= {ff_r[1:0], i_pin};
         lvl_r  <= lvl_nxt;
         rise_r <= lvl_nxt & ~lvl_r;
         fall_r <= ~lvl_nxt & lvl_r;
      end
   end
endmodule : cssfd_sync

/* rtl/cssfd_shift.sv */
// Shift engine: transmit and receive shift registers with bit counter
module cssfd_shift (
   input  wire logic    i_clk,
   input  wire logic    i_arst_n,
   cssfd_shift_if.eng   sif
);
   import cssfd_pkg::*;

   logic [7:0] tx_sh_r;
   logic [7:0] rx_sh_r;
   logic [3:0] cnt_r;
   logic       started_r;
   logic       so_r;
   logic       done_r;
   logic [7:0] rx_data_r;
   logic [7:0] rx_nxt;
   logic [3:0] last_cnt;
   logic       out_ok;
   logic       first_out;

   function automatic logic cur_bit(logic [7:0] v, logic len8, logic lsb);
      cur_bit = lsb ? v[0] : (len8 ? v[7] : v[6]);
   endfunction : cur_bit

   function automatic logic [7:0] shift(logic [7:0] v, logic lsb);
      shift = lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
   endfunction : shift

   assign last_cnt  = sif.len8 ? LEN8_BITS - 4'h1 : LEN7_BITS - 4'h1;
   assign first_out = (cnt_r == 4'h0) && !started_r;
   assign out_ok    = sif.out_edge && !(sif.dap && first_out);
   assign rx_nxt    = sif.lsb ? {sif.si, rx_sh_r[7:1]}
                              : {rx_sh_r[6:0], sif.si};
   assign sif.so      = so_r;
   assign sif.done    = done_r;
   assign sif.rx_data = rx_data_r;
   assign sif.busy    = (cnt_r != 4'h0) || started_r;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tx_sh_r   <= 8'h00;
         rx_sh_r   <= 8'h00;
         cnt_r     <= 4'h0;
         started_r <= 1'b0;
         so_r      <= 1'b1;
         done_r    <= 1'b0;
         rx_data_r <= 8'h00;
      end else if (sif.clr) begin
         tx_sh_r   <= 8'h00;
         cnt_r     <= 4'h0;
         started_r <= 1'b0;
         so_r      <= 1'b1;
         done_r    <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (sif.load && sif.dap) begin
            so_r    <= cur_bit(sif.load_data, sif.len8, sif.lsb);
            tx_sh_r <= shift(sif.load_data, sif.lsb);
         end else if (sif.load) begin
            tx_sh_r <= sif.load_data;
         end else if (out_ok) begin
            so_r      <= cur_bit(tx_sh_r, sif.len8, sif.lsb);
            tx_sh_r   <= shift(tx_sh_r, sif.lsb);
            started_r <= 1'b1;
         end
         if (sif.smp_edge && cnt_r == last_cnt) begin
            cnt_r     <= 4'h0;
            started_r <= 1'b0;
            done_r    <= 1'b1;
            rx_data_r <= sif.len8 ? rx_nxt
                       : {1'b0, sif.lsb ? rx_nxt[7:1] : rx_nxt[6:0]};
         end else if (sif.smp_edge) begin
            cnt_r     <= cnt_r + 4'h1;
            started_r <= 1'b1;
            rx_sh_r   <= rx_nxt;
         end
      end
   end
endmodule : cssfd_shift

/* rtl/cssfd_top.sv */
// Clocked serial slave channel, full duplex, with APB registers
//
// Functional notes
// - Interrupt select picks transfer-end or buffer-empty
// - Overrun is the only receive error flag
// - Shift clock synchronised and sampled internally
// - Data phase: first bit at edge or earlier
// - Polarity bit inverts the incoming shift clock
// - First transmit byte loaded before clocking starts
// - Write while buffer full overwrites pending byte
// - Data read while transmit pending returns it
// - Interrupt select writable while running
// - Clock enable set: wait quiet, then reinitialise
// - Data register low byte is the data port
// - First buffer-empty interrupt precedes any reception
// - Count logic drops then restores interrupt select
// - Stop trigger write halts the channel
// - Data read clears the buffer full flag
// - Flag clear write clears the overrun flag
//
// Register access over APB and the address map were left to the implementer.
module cssfd_top (
   input  wire logic                            I_REF_CLK,
   input  wire logic                            I_ARST_N,
   input  wire logic                            I_PSEL,
   input  wire logic                            I_PENABLE,
   input  wire logic                            I_PWRITE,
   input  wire logic [cssfd_pkg::APB_AW-1:0]    I_PADDR,
   input  wire logic [cssfd_pkg::APB_DW-1:0]    I_PWDATA,
   output logic      [cssfd_pkg::APB_DW-1:0]    O_PRDATA,
   output logic                                 O_PREADY,
   output logic                                 O_PSLVERR,
   input  wire logic                            I_SHIFT_CLOCK_PIN,
   input  wire logic                            I_SERIAL_IN_PIN,
   output logic                                 O_SERIAL_OUT_PIN,
   output logic                                 O_CHANNEL_IRQ
);
   import cssfd_pkg::*;

   //**********************************************
   // Declarations
   //**********************************************
   cssfd_shift_if sif ();

   cssfd_state_t state_r;
   cssfd_state_t state_nxt;
   logic [3:0]   cfg_r;
   logic         md_r;
   logic         md_nxt;
   logic         restore_r;
   logic         restore_nxt;
   logic [7:0]   count_r;
   logic [7:0]   count_nxt;
   logic         pce_r;
   logic [7:0]   tx_buf_r;
   logic         tx_full_r;
   logic [7:0]   rx_buf_r;
   logic         rx_full_r;
   logic         ovf_r;
   logic [1:0]   ist_r;
   logic [1:0]   imask_r;
   logic [7:0]   quiet_r;
   logic [31:0]  prdata_r;
   logic         pready_r;
   logic         pslverr_r;
   logic         irq_r;

   logic         sck_lvl;
   logic         sck_rise;
   logic         sck_fall;
   logic         si_lvl;
   logic         lead;
   logic         trail;
   logic         running;

   logic         setup;
   logic         acc;
   logic         wr;
   logic         rd;
   logic         hit_data;
   logic         hit_mode;
   logic         hit_cfg;
   logic         hit_stat;
   logic         hit_fclr;
   logic         hit_ctrl;
   logic         hit_count;
   logic         hit_istat;
   logic         hit_imask;
   logic         mapped;
   logic [31:0]  rd_val;
   logic         wr_data;
   logic         rd_data;
   logic         start_wr;
   logic         stop_wr;
   logic         ovf_clr;
   logic [1:0]   ist_clr;
   logic         load;
   logic         done;
   logic         ch_ev;
   logic         ov_ev;
   logic         quiet;
   logic         reinit;

   //**********************************************
   // Pin synchronisers
   //**********************************************
   cssfd_sync #(.RST_LVL(1'b1)) u_sck_sync (
      .i_clk    (I_REF_CLK),
      .i_arst_n (I_ARST_N),
      .i_pin    (I_SHIFT_CLOCK_PIN),
      .o_lvl    (sck_lvl),
      .o_rise   (sck_rise),
      .o_fall   (sck_fall)
   );

   cssfd_sync #(.RST_LVL(1'b1)) u_si_sync (
      .i_clk    (I_REF_CLK),
      .i_arst_n (I_ARST_N),
      .i_pin    (I_SERIAL_IN_PIN),
      .o_lvl    (si_lvl),
      .o_rise   (),
      .o_fall   ()
   );

   //**********************************************
   // Shift engine
   //**********************************************
   cssfd_shift u_shift (
      .i_clk    (I_REF_CLK),
      .i_arst_n (I_ARST_N),
      .sif      (sif.eng)
   );

   // Edges only count while running; the master alone makes them
   assign running   = (state_r == ST_RUN);
   assign lead      = cfg_r[CFG_CKP] ? sck_rise : sck_fall;
   assign trail     = cfg_r[CFG_CKP] ? sck_fall : sck_rise;
   assign sif.out_edge  = running && (cfg_r[CFG_DAP] ? trail : lead);
   assign sif.smp_edge  = running && (cfg_r[CFG_DAP] ? lead : trail);
   assign sif.si        = si_lvl;
   assign sif.dap       = cfg_r[CFG_DAP];
   assign sif.len8      = cfg_r[CFG_LEN8];
   assign sif.lsb       = cfg_r[CFG_LSB];
   assign sif.load      = load;
   assign sif.load_data = tx_buf_r;
   assign sif.clr       = reinit || stop_wr;
   assign done          = sif.done;

   // Pending byte moves to the shifter before the master clocks
   assign load  = running && tx_full_r && !sif.busy;

   //**********************************************
   // APB decode
   //**********************************************
   assign setup     = I_PSEL && !I_PENABLE;
   assign acc       = I_PSEL && I_PENABLE && pready_r;
   assign wr        = acc && I_PWRITE;
   assign rd        = acc && !I_PWRITE;
   assign hit_data  = (I_PADDR == ADDR_DATA);
   assign hit_mode  = (I_PADDR == ADDR_MODE);
   assign hit_cfg   = (I_PADDR == ADDR_CFG);
   assign hit_stat  = (I_PADDR == ADDR_STAT);
   assign hit_fclr  = (I_PADDR == ADDR_FCLR);
   assign hit_ctrl  = (I_PADDR == ADDR_CTRL);
   assign hit_count = (I_PADDR == ADDR_COUNT);
   assign hit_istat = (I_PADDR == ADDR_ISTAT);
   assign hit_imask = (I_PADDR == ADDR_IMASK);
   assign mapped    = hit_data | hit_mode | hit_cfg | hit_stat | hit_fclr
                    | hit_ctrl | hit_count | hit_istat | hit_imask;
   assign wr_data   = wr && hit_data;
   assign rd_data   = rd && hit_data;
   assign start_wr  = wr && hit_ctrl && I_PWDATA[CTRL_START];
   assign stop_wr   = wr && hit_ctrl && I_PWDATA[CTRL_STOP];
   assign ovf_clr   = wr && hit_fclr && I_PWDATA[FCLR_OVF];
   assign ist_clr   = (wr && hit_istat) ? I_PWDATA[1:0] : 2'h0;

   // Data read shows a pending transmit byte, else received byte
   assign rd_val =
        hit_data  ? {24'h000000, tx_full_r ? tx_buf_r : rx_buf_r}
      : hit_mode  ? {31'h00000000, md_r}
      : hit_cfg   ? {28'h0000000, cfg_r}
      : hit_stat  ? {28'h0000000, running, sif.busy,
                     tx_full_r | rx_full_r, ovf_r}
      : hit_ctrl  ? {28'h0000000, running, pce_r, 2'h0}
      : hit_count ? {24'h000000, count_r}
      : hit_istat ? {30'h00000000, ist_r}
      : hit_imask ? {30'h00000000, imask_r}
      : 32'h00000000;

   //**********************************************
   // Events
   //**********************************************
   assign ch_ev = (done && !md_r) || (load && md_r);
   assign ov_ev = done && rx_full_r;

   //**********************************************
   // Interrupt select and count
   //**********************************************
   always_comb begin
      md_nxt      = md_r;
      restore_nxt = restore_r;
      count_nxt   = count_r;
      if (load && count_r != 8'h00) begin
         count_nxt = count_r - 8'h01;
         if (count_r == 8'h02 && md_r) begin
            md_nxt      = 1'b0;
            restore_nxt = 1'b1;
         end
      end
      if (done && count_r == 8'h00 && restore_r) begin
         md_nxt      = 1'b1;
         restore_nxt = 1'b0;
      end
      if (wr && hit_count) begin
         count_nxt = I_PWDATA[7:0];
      end
      if (wr && hit_mode) begin
         md_nxt      = I_PWDATA[MODE_ISEL];
         restore_nxt = 1'b0;
      end
   end

   //**********************************************
   // Channel state
   //**********************************************
   assign quiet  = (quiet_r == QUIET_CYC);
   assign reinit = (state_r == ST_DRAIN) && quiet;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_STOP: begin
            if (start_wr && !stop_wr) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (stop_wr) begin
               state_nxt = ST_STOP;
            end
         end
         ST_OFF: begin
            if (pce_r) begin
               state_nxt = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            if (reinit) begin
               state_nxt = ST_STOP;
            end
         end
         default: state_nxt = ST_STOP;
      endcase
      if (!pce_r) begin
         state_nxt = ST_OFF;
      end
   end

   //**********************************************
   // Registers
   //**********************************************
   always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         state_r   <= ST_OFF;
         cfg_r     <= CFG_RST;
         md_r      <= MODE_RST;
         restore_r <= 1'b0;
         count_r   <= 8'h00;
         pce_r     <= PCE_RST;
         imask_r   <= IMASK_RST;
         quiet_r   <= 8'h00;
      end else begin
         state_r   <= state_nxt;
         md_r      <= md_nxt;
         restore_r <= restore_nxt;
         count_r   <= count_nxt;
         quiet_r   <= (sck_rise || sck_fall) ? 8'h00
                    : quiet ? quiet_r : quiet_r + 8'h01;
         if (wr && hit_cfg) begin
            cfg_r <= I_PWDATA[3:0];
         end
         if (wr && hit_ctrl) begin
            pce_r <= I_PWDATA[CTRL_PCE];
         end
         if (wr && hit_imask) begin
            imask_r <= I_PWDATA[1:0];
         end
      end
   end

   // Data buffers and flags; a set in the clearing cycle wins
   always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         tx_buf_r  <= 8'h00;
         tx_full_r <= 1'b0;
         rx_buf_r  <= 8'h00;
         rx_full_r <= 1'b0;
         ovf_r     <= 1'b0;
      end else if (reinit) begin
         tx_full_r <= 1'b0;
         rx_full_r <= 1'b0;
         ovf_r     <= 1'b0;
      end else begin
         tx_buf_r  <= wr_data ? I_PWDATA[7:0] : tx_buf_r;
         tx_full_r <= wr_data || (tx_full_r && !load);
         rx_buf_r  <= done ? sif.rx_data : rx_buf_r;
         rx_full_r <= done || (rx_full_r && !rd_data);
         ovf_r     <= ov_ev || (ovf_r && !ovf_clr);
      end
   end

   //**********************************************
   // Interrupt and bus answer
   //**********************************************
   always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         ist_r     <= 2'h0;
         irq_r     <= 1'b0;
         prdata_r  <= 32'h00000000;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         ist_r     <= {ov_ev, ch_ev} | (ist_r & ~ist_clr);
         irq_r     <= |(ist_r & imask_r);
         pready_r  <= setup;
         pslverr_r <= setup && !mapped;
         prdata_r  <= (setup && !I_PWRITE) ? rd_val : 32'h00000000;
      end
   end

   assign O_PRDATA         = prdata_r;
   assign O_PREADY         = pready_r;
   assign O_PSLVERR        = pslverr_r;
   assign O_SERIAL_OUT_PIN = sif.so;
   assign O_CHANNEL_IRQ    = irq_r;

endmodule : cssfd_top

/* verification/cssfd_chk.sv */
// Port assertions for the serial slave channel
module cssfd_chk (
   input wire logic                         I_REF_CLK,
   input wire logic                         I_ARST_N,
   input wire logic                         I_PSEL,
   input wire logic                         I_PENABLE,
   input wire logic                         I_PWRITE,
   input wire logic [cssfd_pkg::APB_AW-1:0] I_PADDR,
   input wire logic [cssfd_pkg::APB_DW-1:0] O_PRDATA,
   input wire logic                         O_PREADY,
   input wire logic                         O_PSLVERR,
   input wire logic                         I_SHIFT_CLOCK_PIN,
   input wire logic                         O_SERIAL_OUT_PIN,
   input wire logic                         O_CHANNEL_IRQ
);
   timeunit 1ns;
   timeprecision 100ps;
   import cssfd_pkg::*;
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_ARST_N);
   wire        setup_w = I_PSEL && !I_PENABLE;
   wire        unmap_w = I_PADDR > ADDR_IMASK;
   wire        map_w   = !unmap_w && I_PADDR[1:0] == 2'h0;
   wire        rdd_w   = O_PREADY && !I_PWRITE && I_PADDR == ADDR_DATA;
   logic [3:0] wr_age_r, wr_age_nxt, sck_age_r, sck_age_nxt;
   logic       sck_d_r;
   wire        cause_w = wr_age_r < 4'h8 || sck_age_r < 4'hC;
   // Cycles since the last register write and the last clock pin change
   assign wr_age_nxt  = (I_PSEL && I_PENABLE && I_PWRITE) ? 4'h0 :
                        wr_age_r + {3'h0, wr_age_r != 4'hF};
   assign sck_age_nxt = (I_SHIFT_CLOCK_PIN != sck_d_r) ? 4'h0 :
                        sck_age_r + {3'h0, sck_age_r != 4'hF};
   always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         wr_age_r  <= 4'hF;
         sck_age_r <= 4'hF;
         sck_d_r   <= 1'b1;
      end else begin
         wr_age_r  <= wr_age_nxt;
         sck_age_r <= sck_age_nxt;
         sck_d_r   <= I_SHIFT_CLOCK_PIN;
      end
   end
   AST_READY: assert property (setup_w |=> O_PREADY ##1 !O_PREADY)
      else $error("ready not one cycle after setup");
   AST_RDATA_IDLE: assert property (!O_PREADY |-> O_PRDATA == '0)
      else $error("read data not zero outside access");
   AST_RDATA_BYTE: assert property (rdd_w |-> O_PRDATA[31:8] == '0)
      else $error("data port upper bits not zero");
   AST_UNMAP_ERR: assert property (setup_w && unmap_w |=> O_PSLVERR)
      else $error("no error on unmapped address");
   AST_MAP_OK: assert property (setup_w && map_w |=> !O_PSLVERR)
      else $error("error on mapped address");
   AST_SO_SYNC: assert property (sck_age_r == 4'h0 |-> $stable(O_SERIAL_OUT_PIN)[*2])
      else $error("serial out moved before clock synchroniser");
   AST_IRQ_FALL: assert property ($fell(O_CHANNEL_IRQ) |-> wr_age_r < 4'h4)
      else $error("interrupt fell without a register write");
   AST_IRQ_RISE: assert property ($rose(O_CHANNEL_IRQ) |-> cause_w)
      else $error("interrupt rose without a cause");
   CVR_UNMAP: cover property (setup_w && unmap_w);
   CVR_IRQ_UP: cover property ($rose(O_CHANNEL_IRQ));
   CVR_IRQ_DOWN: cover property ($fell(O_CHANNEL_IRQ));
endmodule : cssfd_chk

bind cssfd_top cssfd_chk i_chk (
   .I_REF_CLK(I_REF_CLK), .I_ARST_N(I_ARST_N), .I_PSEL(I_PSEL),
   .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
   .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
   .I_SHIFT_CLOCK_PIN(I_SHIFT_CLOCK_PIN),
   .O_SERIAL_OUT_PIN(O_SERIAL_OUT_PIN), .O_CHANNEL_IRQ(O_CHANNEL_IRQ)
);

/* verification/cssfd_master.sv */
// Behavioural serial master driving the shift clock
module cssfd_master #(
   parameter int HALF_NS = 80
) (
   output logic      o_sck,
   output logic      o_si,
   input  wire logic i_so
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      o_sck = 1'b1;
      o_si  = 1'b0;
   end
   task automatic idle(input logic pol);
      o_sck <= ~pol;
   endtask : idle
   // Clock stands still between frames, data line inverted after the last bit
   task automatic xfer(input logic [7:0] tx, input int nb, input logic pol,
                       input logic dap, input logic lsb,
                       output logic [7:0] rx);
      int k;
      int i;
      rx = 8'h00;
      #3;
      for (k = 0; k < nb; k++) begin
         i = lsb ? k : nb - 1 - k;
         if (dap) o_si = tx[i];
         #HALF_NS o_sck = pol;
         if (dap) rx[i] = i_so;
         else o_si = tx[i];
         #HALF_NS o_sck = ~pol;
         if (!dap) rx[i] = i_so;
      end
      #HALF_NS o_si = ~o_si;
   endtask : xfer
endmodule : cssfd_master

/* verification/cssfd_top_bench.sv */
// Self-checking bench for the serial slave channel
module cssfd_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import cssfd_pkg::*;
   logic        ref_clk = 1'b0;
   logic        arst_n  = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata, r;
   logic        pready, pslverr, sck, si, so, irq, err;
   logic [7:0]  got, got2, m;
   logic [3:0]  c;
   int          n_errors = 0;
   int          compares = 0;
   // Rows: config, device byte, master byte
   localparam logic [19:0] ROWS [8] = '{20'h8A55B, 20'h93CE1, 20'hA960F,
      20'hB7188, 20'hC1E34, 20'hFC37D, 20'h05A26, 20'h76B49};

   cssfd_top i_dut (
      .I_REF_CLK(ref_clk), .I_ARST_N(arst_n), .I_PSEL(psel),
      .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
      .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .I_SHIFT_CLOCK_PIN(sck), .I_SERIAL_IN_PIN(si),
      .O_SERIAL_OUT_PIN(so), .O_CHANNEL_IRQ(irq)
   );
   cssfd_master i_mst (.o_sck(sck), .o_si(si), .i_so(so));

   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic stop_test();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(r, e);
   endtask : rdc

   initial begin
      #100000;
      n_errors++;
      stop_test();
   end

   initial begin
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      rdc(ADDR_CFG, {28'h0, CFG_RST});
      rdc(ADDR_MODE, {31'h0, MODE_RST});
      rdc(ADDR_IMASK, {30'h0, IMASK_RST});
      rdc(8'h24, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, ADDR_CTRL, 32'h4);
      repeat (int'(QUIET_CYC) + 20) @(posedge ref_clk);
      for (int j = 0; j < 8; j++) begin
         c = ROWS[j][19:16];
         m = c[CFG_LEN8] ? 8'hFF : 8'h7F;
         apb(1'b1, ADDR_CTRL, 32'h6);
         rdc(ADDR_CTRL, 32'h4);
         i_mst.idle(c[CFG_CKP]);
         apb(1'b1, ADDR_CFG, {28'h0, c});
         apb(1'b1, ADDR_CTRL, 32'h5);
         apb(1'b1, ADDR_DATA, {24'h0, ROWS[j][15:8]});
         i_mst.xfer(ROWS[j][7:0], c[CFG_LEN8] ? 8 : 7, c[CFG_CKP],
                    c[CFG_DAP], c[CFG_LSB], got);
         repeat (20) @(posedge ref_clk);
         chk({24'h0, got}, {24'h0, ROWS[j][15:8] & m});
         rdc(ADDR_DATA, {24'h0, ROWS[j][7:0] & m});
         rdc(ADDR_ISTAT, 32'h1);
         apb(1'b1, ADDR_ISTAT, 32'h1);
      end
      // Continuous mode: early event, pending overwrite, overrun
      apb(1'b1, ADDR_CTRL, 32'h6);
      i_mst.idle(1'b0);
      apb(1'b1, ADDR_CFG, 32'h8);
      apb(1'b1, ADDR_CTRL, 32'h5);
      apb(1'b1, ADDR_IMASK, 32'h2);
      apb(1'b1, ADDR_MODE, 32'h1);
      apb(1'b1, ADDR_COUNT, 32'h2);
      apb(1'b1, ADDR_DATA, 32'h11);
      repeat (4) @(posedge ref_clk);
      rdc(ADDR_ISTAT, 32'h1);
      chk({31'h0, irq}, 32'h0);
      fork
         i_mst.xfer(8'h22, 8, 1'b0, 1'b0, 1'b0, got);
         begin
            repeat (80) @(posedge ref_clk);
            apb(1'b1, ADDR_DATA, 32'h33);
            rdc(ADDR_DATA, 32'h33);
            apb(1'b1, ADDR_DATA, 32'h44);
            rdc(ADDR_MODE, 32'h0);
         end
      join
      i_mst.xfer(8'h55, 8, 1'b0, 1'b0, 1'b0, got2);
      repeat (20) @(posedge ref_clk);
      chk({24'h0, got}, 32'h11);
      chk({24'h0, got2}, 32'h44);
      rdc(ADDR_MODE, 32'h1);
      rdc(ADDR_COUNT, 32'h0);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(r & 32'h3, 32'h3);
      chk({31'h0, irq}, 32'h1);
      rdc(ADDR_DATA, 32'h55);
      apb(1'b1, ADDR_FCLR, 32'h1);
      apb(1'b0, ADDR_STAT, 32'h0);
      chk(r & 32'h3, 32'h0);
      apb(1'b1, ADDR_ISTAT, 32'h2);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0);
      stop_test();
   end
endmodule : cssfd_top_bench
